/* File: common/pxb_pkg.sv */
package pxb_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_PORTS = 5;
    localparam int XBAR_PORTS = 4;
    localparam int NUM_PINS = 40;
    localparam int XBAR_PINS = 32;
    localparam int NUM_SIGS = 8;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_PORT_DATA0 = 8'h80;
    localparam logic [7:0] IDX_MDIN_BASE = 8'h88;
    localparam logic [7:0] IDX_MDOUT_BASE = 8'h90;
    localparam logic [7:0] IDX_SKIP_BASE = 8'h98;
    localparam logic [7:0] IDX_LATCH_BASE = 8'ha0;
    localparam logic [7:0] IDX_RMW = 8'ha8;
    localparam logic [7:0] IDX_ROUTE0 = 8'hc4;
    localparam logic [7:0] IDX_ROUTE3 = 8'hc7;

    // ==========================================================
    // field positions
    localparam int PUD_BIT = 7;
    localparam int XBAR_EN_BIT = 6;
    localparam int CMP2_ASYNC_BIT = 3;
    localparam int CMP2_SYNC_BIT = 2;
    localparam int UART2_BIT = 1;
    localparam int LIN_BIT = 0;
    localparam int SMB_BIT = 0;
    localparam int RMW_OP_LSB = 0;
    localparam int RMW_PORT_LSB = 4;
    localparam int RMW_BIT_LSB = 8;
    localparam int RMW_OPND_LSB = 16;

    // ==========================================================
    // reset values
    localparam logic [7:0] PORT_DATA_RST = 8'hff;
    localparam logic [7:0] MDIN_RST = 8'hff;
    localparam logic [7:0] MDOUT_RST = 8'h00;
    localparam logic [7:0] SKIP_RST = 8'h00;
    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [7:0] PORT4_MDIN = 8'hff;
    localparam logic [7:0] SENSE_IDLE = 8'hff;

    // ==========================================================
    // crossbar signals in priority order
    typedef enum logic [2:0] {
        SIG_SDA = 3'h0,
        SIG_SCL = 3'h1,
        SIG_LIN_TX = 3'h2,
        SIG_LIN_RX = 3'h3,
        SIG_UART_TX = 3'h4,
        SIG_UART_RX = 3'h5,
        SIG_CMP2_SYNC = 3'h6,
        SIG_CMP2_ASYNC = 3'h7
    } pxb_sig_t;
    localparam logic [7:0] SIG_DRIVES = 8'hd7;
    localparam logic [7:0] SIG_OPEN_DRAIN = 8'h03;

    typedef enum logic [2:0] {
        RMW_AND = 3'h0,
        RMW_OR = 3'h1,
        RMW_XOR = 3'h2,
        RMW_CPL = 3'h3,
        RMW_INC = 3'h4,
        RMW_DEC = 3'h5,
        RMW_CLRB = 3'h6,
        RMW_SETB = 3'h7
    } pxb_rmw_op_t;

endpackage

/* File: verilog/pxb_xbar_assign.sv */
`timescale 1ns/10ps
module pxb_xbar_assign (
    input wire logic [31:0] skip_in,
    input wire logic [7:0] sig_en_in,
    output logic [31:0] assigned_out,
    output logic [31:0][2:0] sig_sel_out
);

    // ==========================================================
    // priority walk: each enabled signal takes the next free pin
    always_comb begin
        logic [3:0] cursor;
        logic found;
        cursor = 4'h0;
        found = 1'b0;
        assigned_out = '0;
        sig_sel_out = '0;
        for (int p = 0; p < pxb_pkg::XBAR_PINS; p++) begin
            found = 1'b0;
            if (!skip_in[p]) begin
                for (int s = 0; s < pxb_pkg::NUM_SIGS; s++) begin
                    if (!found && (4'(s) >= cursor) && sig_en_in[s]) begin
                        found = 1'b1;
                        assigned_out[p] = 1'b1;
                        sig_sel_out[p] = 3'(s);
                        cursor = 4'(s + 1);
                    end
                end
            end
        end
    end

endmodule

/* File: verilog/pxb_port_crossbar.sv */
`timescale 1ns/10ps
// Overview of operation
// - each pin is digital when its input mode bit is one, analog when zero, and all pins reset digital.
// - an analog pin has its weak pull-up, output driver and input receiver switched off.
// - output mode bits pick open-drain or push-pull per pin, but the two-wire bus pins are always open-drain.
// - with pull-up disable at zero, open-drain digital pins get a weak pull-up, push-pull pins never do.
// - a pin actively driving low has its weak pull-up switched off.
// - with the crossbar off, pins are plain inputs, routing is ignored and output drivers stay off.
// - bit 6 of the third routing register enables the crossbar when one and disables it when zero.
// - third routing register bits 3..0 route async comparator-2, sync comparator-2, second uart and lin.
// - ports 0 to 3 have a skip bit per pin that makes the crossbar pass the pin over.
// - a write to a port data register stores the value in the output latch that drives the pin.
// - a normal read of a port data register returns the live levels of digital pins, even routed ones, and zero for analog pins.
// - read-modify-write operations on a port read the latch, not the pins, and write the result back.
// - ports 0 to 3 allow byte and bit access, port 4 only byte access and digital use.
// - the port 0 data register resets to all ones and each written bit sets its latch high or low.
module pxb_port_crossbar (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [39:0] pad_in,
    output logic [39:0] pad_out,
    output logic [39:0] pad_oe_out,
    output logic [39:0] pad_pullup_en_out,
    output logic [39:0] pad_rx_en_out,
    input wire logic [7:0] periph_drive_in,
    output logic [7:0] periph_sense_out,
    output logic xbar_enabled_out
);

    // ==========================================================
    // helpers
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base, input int n);
        return (a >= base) && (int'(a) < int'(base) + n);
    endfunction

    function automatic logic [7:0] rmw_calc(input logic [2:0] op, input logic [7:0] old,
                                            input logic [7:0] opnd, input logic [2:0] bsel);
        logic [7:0] mask;
        mask = 8'h01 << bsel;
        case (op)
            pxb_pkg::RMW_AND: rmw_calc = old & opnd;
            pxb_pkg::RMW_OR: rmw_calc = old | opnd;
            pxb_pkg::RMW_XOR: rmw_calc = old ^ opnd;
            pxb_pkg::RMW_CPL: rmw_calc = old ^ mask;
            pxb_pkg::RMW_INC: rmw_calc = old + 8'h01;
            pxb_pkg::RMW_DEC: rmw_calc = old - 8'h01;
            pxb_pkg::RMW_CLRB: rmw_calc = old & ~mask;
            pxb_pkg::RMW_SETB: rmw_calc = old | mask;
            default: rmw_calc = old;
        endcase
    endfunction

    // ==========================================================
    // state
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [4:0][7:0] latch_ff, nxt_latch;
    logic [3:0][7:0] mdin_ff, nxt_mdin;
    logic [4:0][7:0] mdout_ff, nxt_mdout;
    logic [3:0][7:0] skip_ff, nxt_skip;
    logic [7:0] route3_ff, nxt_route3;
    logic [7:0] route0_ff, nxt_route0;
    logic [7:0] rmw_res_ff, nxt_rmw_res;
    logic [39:0] sync1_ff, sync2_ff;
    logic [39:0] pad_out_ff, nxt_pad_out;
    logic [39:0] pad_oe_ff, nxt_pad_oe;
    logic [39:0] pad_pu_ff, nxt_pad_pu;
    logic [39:0] pad_rx_ff, nxt_pad_rx;
    logic [7:0] sense_ff, nxt_sense;

    logic [7:0] idx;
    logic wr_commit, rd_take;
    logic [2:0] off;
    logic [7:0] rd_byte;
    logic [2:0] rmw_op, rmw_port, rmw_bit;
    logic [39:0] mdin_eff, pp_v, val_v, drv_v;
    logic [4:0][7:0] pin_rd;
    logic [7:0] sig_en;
    logic [31:0] xb_asg;
    logic [31:0][2:0] xb_sel;
    logic xbar_en, pud;

    assign idx = avs_address_in[9:2];
    // a write lands only at the edge where waitrequest is seen low
    assign wr_commit = avs_write_in & ~wait_ff;
    assign rd_take = avs_read_in & wait_ff;
    assign rmw_op = avs_writedata_in[pxb_pkg::RMW_OP_LSB +: 3];
    assign rmw_port = avs_writedata_in[pxb_pkg::RMW_PORT_LSB +: 3];
    assign rmw_bit = avs_writedata_in[pxb_pkg::RMW_BIT_LSB +: 3];
    assign xbar_en = route3_ff[pxb_pkg::XBAR_EN_BIT];
    assign pud = route3_ff[pxb_pkg::PUD_BIT];
    assign mdin_eff = {pxb_pkg::PORT4_MDIN, mdin_ff};
    assign pin_rd = sync2_ff & mdin_eff;
    assign sig_en = {route3_ff[pxb_pkg::CMP2_ASYNC_BIT], route3_ff[pxb_pkg::CMP2_SYNC_BIT],
                     {2{route3_ff[pxb_pkg::UART2_BIT]}}, {2{route3_ff[pxb_pkg::LIN_BIT]}},
                     {2{route0_ff[pxb_pkg::SMB_BIT]}}};

    pxb_xbar_assign u_assign (
        .skip_in(skip_ff),
        .sig_en_in(sig_en),
        .assigned_out(xb_asg),
        .sig_sel_out(xb_sel)
    );

    // ==========================================================
    // register file and bus answer
    always_comb begin
        nxt_wait = ~((avs_read_in | avs_write_in) & wait_ff);
        nxt_rdata = rdata_ff;
        nxt_latch = latch_ff;
        nxt_mdin = mdin_ff;
        nxt_mdout = mdout_ff;
        nxt_skip = skip_ff;
        nxt_route3 = route3_ff;
        nxt_route0 = route0_ff;
        nxt_rmw_res = rmw_res_ff;
        rd_byte = 8'h00;
        off = 3'h0;
        if (in_range(idx, pxb_pkg::IDX_PORT_DATA0, pxb_pkg::NUM_PORTS)) begin
            off = 3'(idx - pxb_pkg::IDX_PORT_DATA0);
            rd_byte = pin_rd[off];
        end else if (in_range(idx, pxb_pkg::IDX_MDIN_BASE, pxb_pkg::XBAR_PORTS)) begin
            off = 3'(idx - pxb_pkg::IDX_MDIN_BASE);
            rd_byte = mdin_ff[off[1:0]];
        end else if (in_range(idx, pxb_pkg::IDX_MDOUT_BASE, pxb_pkg::NUM_PORTS)) begin
            off = 3'(idx - pxb_pkg::IDX_MDOUT_BASE);
            rd_byte = mdout_ff[off];
        end else if (in_range(idx, pxb_pkg::IDX_SKIP_BASE, pxb_pkg::XBAR_PORTS)) begin
            off = 3'(idx - pxb_pkg::IDX_SKIP_BASE);
            rd_byte = skip_ff[off[1:0]];
        end else if (in_range(idx, pxb_pkg::IDX_LATCH_BASE, pxb_pkg::NUM_PORTS)) begin
            off = 3'(idx - pxb_pkg::IDX_LATCH_BASE);
            rd_byte = latch_ff[off];
        end else if (idx == pxb_pkg::IDX_RMW) begin
            rd_byte = rmw_res_ff;
        end else if (idx == pxb_pkg::IDX_ROUTE3) begin
            rd_byte = route3_ff;
        end else if (idx == pxb_pkg::IDX_ROUTE0) begin
            rd_byte = route0_ff;
        end
        if (rd_take) begin
            nxt_rdata = {24'h000000, rd_byte};
        end
        if (wr_commit && idx == pxb_pkg::IDX_RMW) begin
            // whole word needed, and port 4 refuses single-bit forms
            if (&avs_byteenable_in && int'(rmw_port) < pxb_pkg::NUM_PORTS &&
                !(int'(rmw_port) == pxb_pkg::XBAR_PORTS && (rmw_op == pxb_pkg::RMW_CPL ||
                  rmw_op == pxb_pkg::RMW_CLRB || rmw_op == pxb_pkg::RMW_SETB))) begin
                nxt_rmw_res = latch_ff[rmw_port];
                nxt_latch[rmw_port] = rmw_calc(rmw_op, latch_ff[rmw_port],
                                               avs_writedata_in[pxb_pkg::RMW_OPND_LSB +: 8], rmw_bit);
            end
        end else if (wr_commit && avs_byteenable_in[0]) begin
            if (in_range(idx, pxb_pkg::IDX_PORT_DATA0, pxb_pkg::NUM_PORTS)) begin
                nxt_latch[off] = avs_writedata_in[7:0];
            end else if (in_range(idx, pxb_pkg::IDX_MDIN_BASE, pxb_pkg::XBAR_PORTS)) begin
                nxt_mdin[off[1:0]] = avs_writedata_in[7:0];
            end else if (in_range(idx, pxb_pkg::IDX_MDOUT_BASE, pxb_pkg::NUM_PORTS)) begin
                nxt_mdout[off] = avs_writedata_in[7:0];
            end else if (in_range(idx, pxb_pkg::IDX_SKIP_BASE, pxb_pkg::XBAR_PORTS)) begin
                nxt_skip[off[1:0]] = avs_writedata_in[7:0];
            end else if (idx == pxb_pkg::IDX_ROUTE3) begin
                nxt_route3 = avs_writedata_in[7:0];
            end else if (idx == pxb_pkg::IDX_ROUTE0) begin
                nxt_route0 = avs_writedata_in[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
            latch_ff <= {pxb_pkg::NUM_PORTS{pxb_pkg::PORT_DATA_RST}};
            mdin_ff <= {pxb_pkg::XBAR_PORTS{pxb_pkg::MDIN_RST}};
            mdout_ff <= {pxb_pkg::NUM_PORTS{pxb_pkg::MDOUT_RST}};
            skip_ff <= {pxb_pkg::XBAR_PORTS{pxb_pkg::SKIP_RST}};
            route3_ff <= pxb_pkg::ROUTE_RST;
            route0_ff <= pxb_pkg::ROUTE_RST;
            rmw_res_ff <= 8'h00;
        end else begin
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            latch_ff <= nxt_latch;
            mdin_ff <= nxt_mdin;
            mdout_ff <= nxt_mdout;
            skip_ff <= nxt_skip;
            route3_ff <= nxt_route3;
            route0_ff <= nxt_route0;
            rmw_res_ff <= nxt_rmw_res;
        end
    end

    // ==========================================================
    // pad control
    always_comb begin
        val_v = latch_ff;
        drv_v = '1;
        pp_v = mdout_ff;
        nxt_sense = pxb_pkg::SENSE_IDLE;
        for (int p = 0; p < pxb_pkg::XBAR_PINS; p++) begin
            if (xbar_en && xb_asg[p]) begin
                val_v[p] = periph_drive_in[xb_sel[p]];
                drv_v[p] = pxb_pkg::SIG_DRIVES[xb_sel[p]];
                pp_v[p] = mdout_ff[p/8][p%8] & ~pxb_pkg::SIG_OPEN_DRAIN[xb_sel[p]];
                nxt_sense[xb_sel[p]] = sync2_ff[p];
            end
        end
        // an open-drain pin only ever sinks, so driving high is left to the pull-up
        nxt_pad_oe = mdin_eff & {40{xbar_en}} & drv_v & (pp_v | ~val_v);
        nxt_pad_out = val_v;
        nxt_pad_pu = mdin_eff & ~pp_v & {40{~pud}} & ~(nxt_pad_oe & ~val_v);
        nxt_pad_rx = mdin_eff;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            pad_out_ff <= '0;
            pad_oe_ff <= '0;
            pad_pu_ff <= '0;
            pad_rx_ff <= '0;
            sense_ff <= pxb_pkg::SENSE_IDLE;
        end else begin
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff <= nxt_pad_oe;
            pad_pu_ff <= nxt_pad_pu;
            pad_rx_ff <= nxt_pad_rx;
            sense_ff <= nxt_sense;
        end
    end

    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;
    assign pad_out = pad_out_ff;
    assign pad_oe_out = pad_oe_ff;
    assign pad_pullup_en_out = pad_pu_ff;
    assign pad_rx_en_out = pad_rx_ff;
    assign periph_sense_out = sense_ff;
    assign xbar_enabled_out = route3_ff[pxb_pkg::XBAR_EN_BIT];

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    reset_digital_a: assert property (!$past(reset_n_in) |-> mdin_ff == '1)
        else $error("pins not digital after reset");
    port_reset_a: assert property (!$past(reset_n_in) |-> latch_ff[0] == 8'hff)
        else $error("port 0 latch not all ones after reset");
    analog_off_a: assert property (1'b1 |=> ((pad_oe_out | pad_pullup_en_out | pad_rx_en_out)
        & ~$past(mdin_eff)) == '0)
        else $error("analog pin still has a digital path");
    od_no_high_a: assert property (1'b1 |=> (pad_oe_out & pad_out & ~$past(pp_v)) == '0)
        else $error("open-drain pin drove high");
    pullup_rule_a: assert property (1'b1 |=> ((pad_pullup_en_out & $past(pp_v)) == '0) &&
        (!$past(pud) || pad_pullup_en_out == '0))
        else $error("weak pull-up on push-pull pin or while disabled");
    pullup_low_a: assert property ((pad_pullup_en_out & pad_oe_out & ~pad_out) == '0)
        else $error("pull-up left on a pin driving low");
    xbar_off_a: assert property (!xbar_en |=> pad_oe_out == '0)
        else $error("output driven while crossbar off");
    sense_idle_a: assert property (!xbar_en |=> periph_sense_out == pxb_pkg::SENSE_IDLE)
        else $error("peripheral saw a pin while crossbar off");
    xbar_write_a: assert property (wr_commit && avs_byteenable_in[0] && idx == pxb_pkg::IDX_ROUTE3
        |=> xbar_enabled_out == $past(avs_writedata_in[pxb_pkg::XBAR_EN_BIT]))
        else $error("crossbar enable did not follow write");
    skip_pass_a: assert property ((xb_asg & skip_ff) == '0)
        else $error("skipped pin got a signal");
    latch_write_a: assert property (wr_commit && avs_byteenable_in[0] && idx == pxb_pkg::IDX_PORT_DATA0
        |=> latch_ff[0] == $past(avs_writedata_in[7:0]))
        else $error("port 0 latch missed write");
    // the answer stands in the cycle after the taking edge, so data and the low waitrequest meet there
    pin_read_a: assert property (rd_take && idx == pxb_pkg::IDX_PORT_DATA0
        |=> avs_readdata_out[7:0] == $past(pin_rd[0]) && !avs_waitrequest_out)
        else $error("port read did not return pin levels");
    rmw_or_a: assert property (wr_commit && idx == pxb_pkg::IDX_RMW && &avs_byteenable_in &&
        rmw_op == pxb_pkg::RMW_OR && rmw_port == 3'h0
        |=> latch_ff[0] == ($past(latch_ff[0]) | $past(avs_writedata_in[23:16])))
        else $error("latch or did not act on latch");
    port4_bit_a: assert property (wr_commit && idx == pxb_pkg::IDX_RMW && rmw_port == 3'h4 &&
        rmw_op == pxb_pkg::RMW_SETB |=> $stable(latch_ff[4]))
        else $error("bit access changed port 4");
    port4_digital_a: assert property (1'b1 |=> pad_rx_en_out[39:32] == 8'hff)
        else $error("port 4 receiver switched off");

    xbar_on_c: cover property (xbar_en && xb_asg[0] && pad_oe_out[0]);
    rmw_c: cover property (wr_commit && idx == pxb_pkg::IDX_RMW);
    pin_read_c: cover property (rd_take && idx == pxb_pkg::IDX_PORT_DATA0 ##1 !avs_waitrequest_out);
    rmw_refuse_c: cover property (wr_commit && idx == pxb_pkg::IDX_RMW && rmw_port == 3'h4);

endmodule

/* File: test/pxb_pin_model.sv */
`timescale 1ns/10ps
// ==========================================================
// package pins with board circuitry
module pxb_pin_model (
    input wire logic ref_clk_in,
    input wire logic [39:0] pad_val_in,
    input wire logic [39:0] pad_oe_in,
    input wire logic [39:0] pad_pu_in,
    input wire logic [39:0] ext_en_in,
    input wire logic [39:0] ext_val_in,
    output logic [39:0] level_out
);
    logic [39:0] float_ff = 40'h0;

    // an undriven pin without pull-up wanders, so no check may lean on it
    always_ff @(posedge ref_clk_in) begin
        float_ff <= ~float_ff;
    end

    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (pad_oe_in[i]) begin
                level_out[i] = pad_val_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pad_pu_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = float_ff[i];
            end
        end
    end
endmodule

/* File: test/pxb_port_crossbar_bench.sv */
`timescale 1ns/10ps
module pxb_port_crossbar_bench;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [9:0] addr = 10'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] rdata;
    logic wait_r;
    logic [39:0] pin_lvl, pout, poe, ppu, prx;
    logic [39:0] ext_en = 40'h0;
    logic [39:0] ext_val = 40'h0;
    logic [7:0] drv = 8'h0;
    logic [7:0] sense;
    logic xen;
    logic [31:0] exp_q[$];
    logic [31:0] rng = 32'hba95;
    int fails = 0;
    int cmp_count = 0;

    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    pxb_port_crossbar pxb_port_crossbar_i (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .avs_address_in(addr),
        .avs_read_in(rd),
        .avs_write_in(wr),
        .avs_writedata_in(wdata),
        .avs_byteenable_in(be),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_r),
        .pad_in(pin_lvl),
        .pad_out(pout),
        .pad_oe_out(poe),
        .pad_pullup_en_out(ppu),
        .pad_rx_en_out(prx),
        .periph_drive_in(drv),
        .periph_sense_out(sense),
        .xbar_enabled_out(xen)
    );

    pxb_pin_model pxb_pin_model_i (
        .ref_clk_in(ref_clk_in),
        .pad_val_in(pout),
        .pad_oe_in(poe),
        .pad_pu_in(ppu),
        .ext_en_in(ext_en),
        .ext_val_in(ext_val),
        .level_out(pin_lvl)
    );

    // ==========================================================
    // checking and bus tasks
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [7:0] op_exp(input logic [2:0] op, input logic [7:0] v, input logic [2:0] b);
        case (op)
            3'h0: return v & 8'h3c;
            3'h1: return v | 8'h3c;
            3'h2: return v ^ 8'h3c;
            3'h3: return v ^ (8'h01 << b);
            3'h4: return v + 8'h01;
            3'h5: return v - 8'h01;
            3'h6: return v & ~(8'h01 << b);
            default: return v | (8'h01 << b);
        endcase
    endfunction

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge ref_clk_in);
        rd <= ~w;
        wr <= w;
        addr <= {idx, 2'b00};
        wdata <= d;
        be <= b;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            final_report();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d}, 4'h1);
    endtask

    task automatic rreg(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, idx, 32'h0, 4'h1);
    endtask

    // answers are matched against the oldest note left by the driver
    always @(posedge ref_clk_in) begin
        if (rd && wait_r === 1'b0) begin
            if (exp_q.size() == 0) begin
                check({8'h0, rdata}, 40'hff_ffff_ffff);
            end else begin
                check({8'h0, rdata}, {8'h0, exp_q.pop_front()});
            end
        end
    end

    // ==========================================================
    // scenarios
    initial begin
        logic [7:0] lat;
        logic [31:0] r;
        logic [39:0] e;
        repeat (4) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        check(prx, {40{1'b1}});
        check(poe, 40'h0);
        check(ppu, {40{1'b1}});
        rreg(8'h88, 8'hff);
        rreg(8'ha0, 8'hff);
        rreg(8'h80, 8'hff);
        rreg(8'hc7, 8'h00);
        wreg(8'h00, 8'h77);
        rreg(8'h00, 8'h00);
        wreg(8'h80, 8'h5a);
        wreg(8'h90, 8'h0f);
        wreg(8'hc7, 8'h40);
        repeat (4) @(posedge ref_clk_in);
        check(poe & 40'hff, 40'haf);
        check(ppu & 40'hff, 40'h50);
        check(pout & 40'hff, 40'h5a);
        check({39'h0, xen}, 40'h1);
        rreg(8'h80, 8'h5a);
        wreg(8'hc7, 8'hc0);
        repeat (3) @(posedge ref_clk_in);
        check(ppu, 40'h0);
        wreg(8'hc7, 8'h40);
        wreg(8'h88, 8'h0f);
        repeat (4) @(posedge ref_clk_in);
        check(prx & 40'hff, 40'h0f);
        check(ppu & 40'hff, 40'h00);
        check(poe & 40'hff, 40'h0f);
        rreg(8'h80, 8'h0a);
        // crossbar off first, then set up in the documented order
        wreg(8'hc7, 8'h00);
        wreg(8'h88, 8'hff);
        wreg(8'h90, 8'hff);
        wreg(8'h98, 8'h05);
        wreg(8'hc4, 8'h01);
        wreg(8'hc7, 8'h4f);
        ext_en <= 40'ha0;
        for (int k = 0; k < 4; k++) begin
            r = xs();
            drv <= r[7:0];
            ext_val <= {8'h0, r};
            repeat (5) @(posedge ref_clk_in);
            e = {30'h0, ~drv[7], ~drv[6], 2'b01, 2'b01, ~drv[1], 1'b1, ~drv[0], 1'b1};
            check(poe & 40'h3ff, e);
            e = {30'h0, drv[7], drv[6], 1'b0, drv[4], 1'b0, drv[2], drv[1], 1'b0, drv[0], 1'b0};
            check(pout & 40'h35a, e);
            check({32'h0, sense & 8'h28}, {32'h0, 2'b00, r[7], 1'b0, r[5], 3'b000});
            rreg(8'h80, {r[7], r[4], r[5], r[2], r[1], 1'b0, r[0], 1'b0});
        end
        wreg(8'hc7, 8'h0f);
        ext_en <= 40'h0;
        repeat (4) @(posedge ref_clk_in);
        check(poe, 40'h0);
        check({39'h0, xen}, 40'h0);
        check({32'h0, sense}, 40'hff);
        wreg(8'h80, 8'h5a);
        lat = 8'h5a;
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, 8'ha8, {8'h0, 8'h3c, 5'h0, 3'h3, 1'b0, 3'h0, 1'b0, k[2:0]}, 4'hf);
            rreg(8'ha8, lat);
            lat = op_exp(k[2:0], lat, 3'h3);
            rreg(8'ha0, lat);
        end
        wreg(8'h84, 8'h33);
        bus(1'b1, 8'ha8, {8'h0, 8'hff, 5'h0, 3'h0, 1'b0, 3'h4, 1'b0, 3'h7}, 4'hf);
        rreg(8'ha4, 8'h33);
        repeat (3) @(posedge ref_clk_in);
        check({8'h0, exp_q.size()}, 40'h0);
        final_report();
    end
endmodule
